// *** src/audio_tx_in_cfg.svh ***
// Constants for the serial audio input stage of the transmitter.
`ifndef AUDIO_TX_IN_CFG_SVH
`define AUDIO_TX_IN_CFG_SVH
`define ADR_CTRL 8'h00
`define ADR_STATUS 8'h04
`define ADR_LEFT 8'h08
`define ADR_RIGHT 8'h0c
`define CTRL_EN_BIT 0
`define CTRL_FMT_LSB 1
`define CTRL_WID_LSB 3
`define CTRL_RATIO_BIT 5
`define STAT_LEFT_BIT 0
`define STAT_RIGHT_BIT 1
`define STAT_OVR_BIT 2
`define FMT_LJ 2'h0
`define FMT_I2S 2'h1
`define FMT_RJ 2'h2
`define WCODE_16 2'h0
`define WCODE_18 2'h1
`define WCODE_20 2'h2
`define WCODE_24 2'h3
`define RST_FMT 2'h1
`define RST_WCODE 2'h3
`define WIDTH_16 5'd16
`define WIDTH_18 5'd18
`define WIDTH_20 5'd20
`define WIDTH_24 5'd24
`define RJ_DELAY_16 7'd16
`define RJ_DELAY_18 7'd14
`define RJ_DELAY_20 7'd12
`define RJ_DELAY_24 7'd8
`define I2S_DELAY 7'd1
`define LJ_DELAY 7'd0
`define BIT_IDX_MAX 7'd63
`define DIV_256 2'd2
`define DIV_384 2'd3
`endif

// *** src/audio_tx_in_pkg.sv ***
// Types shared by the serial audio input stage.
`include "audio_tx_in_cfg.svh"
package audio_tx_in_pkg;
  typedef enum logic [1:0] {
    fmt_left_just = `FMT_LJ,
    fmt_i2s = `FMT_I2S,
    fmt_right_just = `FMT_RJ
  } fmt_type;
  typedef enum logic [1:0] {
    cap_wait = 2'b01,
    cap_run = 2'b10
  } cap_state_type;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } sync_state_type;
  typedef struct packed {
    logic [1:0] cnt;
    logic tick;
  } div_state_type;
  typedef struct packed {
    logic enable;
    logic [1:0] fmt;
    logic [1:0] wcode;
    logic ratio384;
    logic [2:0] stat;
    logic [23:0] left;
    logic [23:0] right;
    logic [23:0] shreg;
    logic [6:0] bitcnt;
    logic [4:0] nbits;
    logic fs_prev;
    logic slot_left;
    cap_state_type cap_state;
    logic wb_ack;
    logic [31:0] wb_dat;
    logic strobe;
    logic is_left;
  } top_state_type;
endpackage : audio_tx_in_pkg

// *** src/pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter and rising-edge pulse.
`timescale 1ns/1ps
module pin_sync (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise
);
  audio_tx_in_pkg::sync_state_type q, d;

  always_comb begin
    d = q;
    d.s1 = i_pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.rise = 1'b0;
    if (q.s2 == q.s3) begin
      d.level = q.s3;
      d.rise = q.s3 && !q.level;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_level = q.level;
  assign o_rise = q.rise;
endmodule : pin_sync

// *** src/biphase_divider.sv ***
// Divides oversampling clock edges down to the biphase clock enable.
`timescale 1ns/1ps
`include "audio_tx_in_cfg.svh"
module biphase_divider (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_osc_rise,
  input wire logic i_ratio384,
  output logic o_tick
);
  audio_tx_in_pkg::div_state_type q, d;
  logic [1:0] div;

  always_comb begin
    div = i_ratio384 ? `DIV_384 : `DIV_256;
    d = q;
    d.tick = 1'b0;
    if (i_osc_rise) begin
      if (q.cnt >= div - 2'd1) begin
        d.cnt = 2'd0;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 2'd1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_tick = q.tick;

  a_tick_on_edge: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_tick |-> $past(i_osc_rise)) else $error("biphase tick without oscillator edge");
  a_tick_ratio: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_osc_rise && q.cnt == div - 2'd1) |=> o_tick)
    else $error("biphase tick missing at ratio count");
endmodule : biphase_divider

// *** src/digital_audio_tx_serial_input.sv ***
// Serial audio input stage of the transmitter with a Wishbone register file.
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "audio_tx_in_cfg.svh"
module digital_audio_tx_serial_input (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_serial_clk,
  input wire logic i_frame_sync,
  input wire logic i_serial_data,
  input wire logic i_oversampling_clock,
  output logic [23:0] o_left_sample,
  output logic [23:0] o_right_sample,
  output logic o_sample_strobe,
  output logic o_sample_is_left,
  output logic o_biphase_tick
);
  audio_tx_in_pkg::top_state_type q, d;
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic [3:0] pins;
  logic [3:0] lvl;
  logic [3:0] rise;
  logic fs, sd, sclk_rise;
  logic fs_change, slot_left, chan, req, wr_status;
  logic [6:0] idx, start;
  logic [4:0] nb, width;
  logic [23:0] sh;
  logic [2:0] set, clr;

  function automatic logic [4:0] width_of(input logic [1:0] wcode);
    case (wcode)
      `WCODE_16: width_of = `WIDTH_16;
      `WCODE_18: width_of = `WIDTH_18;
      `WCODE_20: width_of = `WIDTH_20;
      default: width_of = `WIDTH_24;
    endcase
  endfunction : width_of

  // Bit index within the slot, counted from the sync transition, of the MSB.
  function automatic logic [6:0] msb_start(input logic [1:0] fmt, input logic [1:0] wcode);
    case (fmt)
      `FMT_I2S: msb_start = `I2S_DELAY;
      `FMT_RJ: begin
        case (wcode)
          `WCODE_16: msb_start = `RJ_DELAY_16;
          `WCODE_18: msb_start = `RJ_DELAY_18;
          `WCODE_20: msb_start = `RJ_DELAY_20;
          default: msb_start = `RJ_DELAY_24;
        endcase
      end
      default: msb_start = `LJ_DELAY;
    endcase
  endfunction : msb_start

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Pins routed in from the routing unit are asynchronous to the system clock.
  assign pins = {i_oversampling_clock, i_serial_data, i_frame_sync, i_serial_clk};
  generate
    for (genvar g = 0; g < 4; g++) begin : g_sync
      pin_sync u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(rst_sync_ff),
        .i_pin(pins[g]),
        .o_level(lvl[g]),
        .o_rise(rise[g])
      );
    end
  endgenerate

  biphase_divider u_div (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_sync_ff),
    .i_osc_rise(rise[3]),
    .i_ratio384(q.ratio384),
    .o_tick(o_biphase_tick)
  );

  assign sclk_rise = rise[0];
  assign fs = lvl[1];
  assign sd = lvl[2];
  assign fs_change = fs != q.fs_prev;
  assign slot_left = (q.fmt == `FMT_I2S) ? !fs : fs;
  assign req = i_wb_cyc && i_wb_stb && !q.wb_ack;
  assign wr_status = req && i_wb_we && i_wb_adr == `ADR_STATUS && i_wb_sel[0];
  assign clr = wr_status ? i_wb_dat[2:0] : 3'h0;
  assign width = width_of(q.wcode);
  assign start = msb_start(q.fmt, q.wcode);

  always_comb begin
    d = q;
    d.wb_ack = 1'b0;
    d.strobe = 1'b0;
    set = 3'h0;
    idx = fs_change ? 7'd0 : q.bitcnt;
    nb = fs_change ? 5'd0 : q.nbits;
    sh = fs_change ? 24'h0 : q.shreg;
    chan = fs_change ? slot_left : q.slot_left;
    if (req) begin
      d.wb_ack = 1'b1;
      d.wb_dat = 32'h0;
      if (i_wb_we) begin
        if (i_wb_adr == `ADR_CTRL && i_wb_sel[0]) begin
          d.enable = i_wb_dat[`CTRL_EN_BIT];
          d.fmt = i_wb_dat[`CTRL_FMT_LSB +: 2];
          d.wcode = i_wb_dat[`CTRL_WID_LSB +: 2];
          d.ratio384 = i_wb_dat[`CTRL_RATIO_BIT];
        end
      end else begin
        case (i_wb_adr)
          `ADR_CTRL: d.wb_dat = {26'h0, q.ratio384, q.wcode, q.fmt, q.enable};
          `ADR_STATUS: d.wb_dat = {29'h0, q.stat};
          `ADR_LEFT: d.wb_dat = {8'h0, q.left};
          `ADR_RIGHT: d.wb_dat = {8'h0, q.right};
          default: d.wb_dat = 32'h0;
        endcase
      end
    end
    if (sclk_rise) begin
      d.fs_prev = fs;
      if (!q.enable) begin
        d.cap_state = audio_tx_in_pkg::cap_wait;
      end else begin
        if (fs_change) begin
          d.cap_state = audio_tx_in_pkg::cap_run;
          d.slot_left = slot_left;
        end
        case (q.cap_state)
          audio_tx_in_pkg::cap_wait, audio_tx_in_pkg::cap_run: begin
            if ((fs_change || q.cap_state == audio_tx_in_pkg::cap_run) &&
                idx >= start && nb < width) begin
              sh = {sh[22:0], sd};
              nb = nb + 5'd1;
              if (nb == width) begin
                d.strobe = 1'b1;
                d.is_left = chan;
                if (chan) begin
                  d.left = sh;
                  set[`STAT_LEFT_BIT] = 1'b1;
                end else begin
                  d.right = sh;
                  set[`STAT_RIGHT_BIT] = 1'b1;
                end
                set[`STAT_OVR_BIT] = chan ? q.stat[`STAT_LEFT_BIT] : q.stat[`STAT_RIGHT_BIT];
              end
            end
          end
          default: d.cap_state = audio_tx_in_pkg::cap_wait;
        endcase
        d.shreg = sh;
        d.nbits = nb;
        d.bitcnt = (idx == `BIT_IDX_MAX) ? `BIT_IDX_MAX : idx + 7'd1;
      end
    end
    // A flag set in the same cycle as its clear stays set.
    d.stat = (q.stat & ~clr) | set;
  end

  always_ff @(posedge i_sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      q <= '0;
      q.fmt <= `RST_FMT;
      q.wcode <= `RST_WCODE;
      q.cap_state <= audio_tx_in_pkg::cap_wait;
    end else begin
      q <= d;
    end
  end

  assign o_wb_dat = q.wb_dat;
  assign o_wb_ack = q.wb_ack;
  assign o_left_sample = q.left;
  assign o_right_sample = q.right;
  assign o_sample_strobe = q.strobe;
  assign o_sample_is_left = q.is_left;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!rst_sync_ff);

  a_ack_answers: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("wishbone ack not a single cycle after request");
  a_lj_msb_first: assert property (sclk_rise && fs_change && q.enable && q.fmt == `FMT_LJ
    |=> q.nbits == 5'd1) else $error("left-justified MSB not taken at sync edge");
  a_i2s_msb_late: assert property (sclk_rise && fs_change && q.enable && q.fmt == `FMT_I2S
    |=> q.nbits == 5'd0) else $error("I2S MSB taken without one clock delay");
  a_rj_msb_delay: assert property (sclk_rise && !fs_change && q.enable &&
    q.cap_state == audio_tx_in_pkg::cap_run && q.fmt == `FMT_RJ && q.bitcnt == start
    |=> q.nbits == $past(q.nbits) + 5'd1) else $error("right-justified MSB slot missed");
  a_rj_no_early: assert property (sclk_rise && !fs_change && q.fmt == `FMT_RJ &&
    q.bitcnt < start |=> q.nbits == 5'd0) else $error("right-justified bit taken early");
  a_word_width: assert property (o_sample_strobe |-> $past(q.nbits) == width - 5'd1)
    else $error("sample completed at wrong width");
  a_slot_chan: assert property (o_sample_strobe |-> o_sample_is_left ==
    ($past(fs) ^ ($past(q.fmt) == `FMT_I2S))) else $error("sample in wrong channel");
  a_shift_on_sclk: assert property (q.nbits != $past(q.nbits) && q.nbits != 5'd0
    |-> $past(sclk_rise)) else $error("bit shifted without serial clock edge");
  a_set_wins: assert property (set[`STAT_LEFT_BIT] && clr[`STAT_LEFT_BIT]
    |=> q.stat[`STAT_LEFT_BIT]) else $error("left flag lost to clear");
  a_left_data: assert property (o_sample_strobe && o_sample_is_left
    |-> o_left_sample == $past(d.left)) else $error("left sample register mismatch");
endmodule : digital_audio_tx_serial_input

// *** verification/audio_source_model.sv ***
// Behavioural serial audio source that frames samples for the input stage.
`timescale 1ns/1ps
module audio_source_model (
  output logic o_serial_clk,
  output logic o_frame_sync,
  output logic o_serial_data
);
  initial begin
    o_serial_clk = 1'b0;
    o_frame_sync = 1'b0;
    o_serial_data = 1'b0;
  end

  // One frame of 64 clocks; bits outside the word toggle so stale data cannot pass.
  task automatic frame(input logic [1:0] fmt, input int nbits, input logic [23:0] l,
                       input logic [23:0] r);
    int d;
    logic [23:0] w;
    d = (fmt == 2'h1) ? 1 : ((fmt == 2'h2) ? 32 - nbits : 0);
    for (int ch = 0; ch < 2; ch++) begin
      w = (ch == 0) ? l : r;
      for (int b = 0; b < 32; b++) begin
        o_frame_sync = (ch == 0) ^ (fmt == 2'h1);
        o_serial_data = (b >= d && b < d + nbits) ? w[nbits - 1 - b + d] : ~o_serial_data;
        #48 o_serial_clk = 1'b1;
        #48 o_serial_clk = 1'b0;
      end
    end
  endtask : frame
endmodule : audio_source_model

// *** verification/test_digital_audio_tx_serial_input.sv ***
// Self-checking bench for the serial audio input stage and its registers.
`timescale 1ns/1ps
module test_digital_audio_tx_serial_input;
  logic clk, arst_n, cyc, stb, we, osc, strobe, is_left, tick, sclk, fs, sdata, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, q, rd, exp_l;
  logic [23:0] l, r, left, right, mask;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  int strobes = 0;
  int nb[4] = '{16, 18, 20, 24};

  digital_audio_tx_serial_input digital_audio_tx_serial_input_inst (
    .i_sys_clk(clk), .i_arst_n(arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dw), .o_wb_dat(rd), .o_wb_ack(ack),
    .i_serial_clk(sclk), .i_frame_sync(fs), .i_serial_data(sdata),
    .i_oversampling_clock(osc), .o_left_sample(left), .o_right_sample(right),
    .o_sample_strobe(strobe), .o_sample_is_left(is_left), .o_biphase_tick(tick)
  );
  audio_source_model audio_source_model_inst (
    .o_serial_clk(sclk), .o_frame_sync(fs), .o_serial_data(sdata)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    forever #40 osc = ~osc;
  end

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cycles++;
    if (strobe === 1'b1) strobes++;
    if (cycles == 40000) begin
      failures++;
      print_verdict;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Classic single cycle; called just after a rising edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] data);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= s;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k == 20) failures++;
    data = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  initial begin
    arst_n = 1'b0;
    {cyc, stb, we, adr, sel, dw} = '0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    wb(1'b0, 8'h00, 32'h0, 4'hf, q);
    chk(q, 32'h0000001a);
    wb(1'b1, 8'h10, 32'hffffffff, 4'hf, q);
    wb(1'b0, 8'h10, 32'h0, 4'hf, q);
    chk(q, 32'h0);
    for (int f = 0; f < 3; f++) begin
      for (int w = 0; w < 4; w++) begin
        wb(1'b1, 8'h00, {26'h0, 1'b0, 2'(w), 2'(f), 1'b1}, 4'hf, q);
        l = 24'h9b3c5e + 24'h013579 * (f * 4 + w);
        r = l ^ 24'h5a5a5a;
        mask = 24'hffffff >> (24 - nb[w]);
        repeat (2) audio_source_model_inst.frame(2'(f), nb[w], l, r);
        n = strobes;
        audio_source_model_inst.frame(2'(f), nb[w], l, r);
        repeat (8) @(posedge clk);
        exp_l = {8'h0, l & mask};
        chk(32'(strobes - n), 32'd2);
        chk({8'h0, left}, exp_l);
        chk({8'h0, right}, {8'h0, r & mask});
        chk({31'h0, is_left}, 32'h0);
        wb(1'b0, 8'h08, 32'h0, 4'hf, q);
        chk(q, exp_l);
        wb(1'b0, 8'h0c, 32'h0, 4'hf, q);
        chk(q, {8'h0, r & mask});
        wb(1'b0, 8'h04, 32'h0, 4'hf, q);
        chk(q, 32'h7);
        wb(1'b1, 8'h04, 32'h7, 4'hf, q);
        wb(1'b0, 8'h04, 32'h0, 4'hf, q);
        chk(q, 32'h0);
        $display("test format %0d width %0d done", f, nb[w]);
      end
    end
    // Disabled capture keeps the last sample; a write without byte lane 0 is ignored.
    wb(1'b1, 8'h00, 32'h18, 4'hf, q);
    n = strobes;
    audio_source_model_inst.frame(2'h0, 24, ~l, ~r);
    repeat (8) @(posedge clk);
    chk(32'(strobes - n), 32'd0);
    chk({8'h0, left}, exp_l);
    wb(1'b0, 8'h08, 32'h0, 4'hf, q);
    chk(q, exp_l);
    wb(1'b1, 8'h00, 32'h21, 4'he, q);
    wb(1'b0, 8'h00, 32'h0, 4'hf, q);
    chk(q, 32'h18);
    $display("test disable and byte lane done");
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, 8'h00, {26'h0, k[0], 5'h18}, 4'hf, q);
      repeat (2) @(posedge tick);
      @(negedge tick);
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (tick !== 1'b1 && n < 100);
      chk(32'(n), k ? 32'd30 : 32'd20);
    end
    $display("test biphase divider done");
    @(posedge clk);
    print_verdict;
  end
endmodule : test_digital_audio_tx_serial_input
